// *** verilog/dac_ref_ctrl.sv ***
// Behaviour
// R01: enable bit turns converter on or off
// R02: ten-bit code selects one of 1024 levels
// R03: left format: high holds 9..2, low top two
// R04: right format: low holds 7..0, high 9..8
// R05: level writes staged, active code unchanged
// R06: load strobe copies staged code atomically
// R07: strobe self-clears; zero leaves buffers alone
// R08: strobe bits 4,1,0; others read zero
// R09: control bits 5,4 connect output pins
// R10: selected pin loses digital driver and input
// R11: digital read of analog pin is zero
// R12: level always offered to internal consumers
// R13: bits 3..2 pick positive source; 11 reserved
// R14: bits 1..0 pick negative source; 11 reserved
// R15: reset disables, disconnects, clears the code
// R16: wake from sleep keeps control contents
// R17: software should disable before sleep
// R18: three independent instances share load register
//
// The register addresses and the Wishbone register port were left to the implementer.
`default_nettype none
module dac_ref_ctrl
    import dac_ref_pkg::*;
#(
    parameter int N = NUM_INST
)
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [WB_AW-1:0]        wb_adr_i,
    input  wire logic [WB_DW/8-1:0]      wb_sel_i,
    input  wire logic [WB_DW-1:0]        wb_dat_i,
    output var  logic [WB_DW-1:0]        wb_dat_o,
    output var  logic                    wb_ack_o,
    input  wire logic [N*PINS_PER-1:0]   pin_din_i,
    output var  logic [N*PINS_PER-1:0]   pin_read_o,
    output var  logic [N*PINS_PER-1:0]   pin_analog_o,
    output var  logic [N*PINS_PER-1:0]   pin_digital_off_o,
    output var  logic [N*CODE_W-1:0]     level_code_o,
    output var  logic [N-1:0]            enable_o,
    output var  logic [N*SEL_W-1:0]      pos_sel_o,
    output var  logic [N*SEL_W-1:0]      neg_sel_o,
    output var  logic [N-1:0]            source_valid_o
);
    // the shared load register has room for exactly three strobes
    if (N != NUM_INST)
    begin : g_bad_count
        $error("instance count must match the shared load register");
    end

    typedef struct packed
    {
        logic                  ack;
        logic [WB_DW-1:0]      rdata;
        logic [N-1:0]          load;
        logic [N*PINS_PER-1:0] pin_read;
        logic [N*PINS_PER-1:0] pin_analog;
        logic [N*CODE_W-1:0]   level;
        logic [N-1:0]          enable;
        logic [N*SEL_W-1:0]    pos_sel;
        logic [N*SEL_W-1:0]    neg_sel;
        logic [N-1:0]          valid;
    } top_state_type;

    top_state_type st;
    top_state_type next_st;

    logic             req;
    logic             wr_now;
    logic [3:0]       slot;
    logic [1:0]       word;
    logic [REG_W-1:0] load_rd;
    logic [REG_W-1:0] inst_rd [N];

    logic [REG_W-1:0]  ctrl_of   [N];
    logic [CODE_W-1:0] active_of [N];
    logic              ok_of     [N];

    chan_if link [N] ();

    assign req    = wb_cyc_i && wb_stb_i;
    assign wr_now = req && wb_we_i && st.ack && wb_sel_i[0];
    assign slot   = wb_adr_i[SLOT_MSB:SLOT_LSB];
    assign word   = wb_adr_i[WORD_MSB:WORD_LSB];

    // one generate block per converter instance
    for (genvar k = 0; k < N; k++)
    begin : g_inst
        localparam logic [3:0] IDX = 4'(k);
        logic                  sel_here;
        logic                  pos_ok;
        logic                  neg_ok;

        assign sel_here          = (slot == IDX) && (wb_adr_i[1:0] == 2'h0);
        assign link[k].wr_ctrl   = wr_now && sel_here && (word == CTRL_WORD);
        assign link[k].wr_high   = wr_now && sel_here && (word == HIGH_WORD); // R05
        assign link[k].wr_low    = wr_now && sel_here && (word == LOW_WORD); // R05
        assign link[k].wdata     = wb_dat_i[REG_W-1:0];
        assign link[k].load      = st.load[k]; // R06
        assign ctrl_of[k]        = link[k].ctrl;
        assign active_of[k]      = link[k].active; // R12
        assign ok_of[k]          = pos_ok && neg_ok; // R13 R14

        always_comb
        begin
            if (!sel_here)
                inst_rd[k] = ZERO_BYTE;
            else
            begin
                unique case (word)
                    CTRL_WORD: inst_rd[k] = link[k].ctrl;
                    HIGH_WORD: inst_rd[k] = link[k].high_rd;
                    LOW_WORD:  inst_rd[k] = link[k].low_rd;
                    default:   inst_rd[k] = ZERO_BYTE;
                endcase
            end
        end

        assign pos_ok = link[k].ctrl[POS_SEL_LSB+:SEL_W] != SRC_RESERVED; // R13
        assign neg_ok = (link[k].ctrl[NEG_SEL_LSB+:SEL_W] != SRC_RESERVED)
                     && ((link[k].ctrl[NEG_SEL_LSB+:SEL_W] != NEG_REF_ONE) || (k == NEG_ONE_INST)); // R14

        converter_channel u_channel
        (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .link  (link[k])
        ); // R18

        sequence s_load_write;
            wr_now && (wb_adr_i == LOAD_ADDR) && wb_dat_i[LOAD_BIT[k]];
        endsequence

        sequence s_pending_then_clear;
            st.load[k] ##1 !st.load[k];
        endsequence

        a_load_sets_clears: assert property (@(posedge clk_i) disable iff (rst_i) // R07
            s_load_write |=> s_pending_then_clear)
            else $error("load strobe did not set then clear");

        a_load_copies_code: assert property (@(posedge clk_i) disable iff (rst_i) // R06
            st.load[k] |=> (link[k].active == $past(link[k].staged)))
            else $error("load did not copy staged code");

        a_level_follows: assert property (@(posedge clk_i) disable iff (rst_i) // R12
            ##1 (level_code_o[k*CODE_W+:CODE_W] == $past(link[k].active)))
            else $error("internal level does not follow active code");

        a_enable_follows: assert property (@(posedge clk_i) disable iff (rst_i) // R01
            ##1 (enable_o[k] == $past(link[k].ctrl[ENABLE_BIT])))
            else $error("enable output does not follow control");

        a_pin_one_route: assert property (@(posedge clk_i) disable iff (rst_i) // R09
            link[k].ctrl[PIN_ONE_BIT] |=> pin_analog_o[k*PINS_PER] && pin_digital_off_o[k*PINS_PER])
            else $error("pin one not routed to converter");

        a_analog_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R11
            pin_analog_o[k*PINS_PER+1] |-> !pin_read_o[k*PINS_PER+1])
            else $error("analog pin read not zero");

        sequence s_ctrl_write;
            link[k].wr_ctrl;
        endsequence

        sequence s_outputs_follow;
            (enable_o[k] == $past(link[k].wdata[ENABLE_BIT], 2))
            && (pos_sel_o[k*SEL_W+:SEL_W] == $past(link[k].wdata[POS_SEL_LSB+:SEL_W], 2))
            && (neg_sel_o[k*SEL_W+:SEL_W] == $past(link[k].wdata[NEG_SEL_LSB+:SEL_W], 2));
        endsequence

        a_ctrl_reaches_out: assert property (@(posedge clk_i) disable iff (rst_i) // R01 R13 R14
            s_ctrl_write |=> ##1 s_outputs_follow)
            else $error("control write did not reach outputs");

        a_pin_two_route: assert property (@(posedge clk_i) disable iff (rst_i) // R09
            link[k].ctrl[PIN_TWO_BIT] |=> pin_analog_o[k*PINS_PER+1] && pin_digital_off_o[k*PINS_PER+1])
            else $error("pin two not routed to converter");

        a_pin_one_off: assert property (@(posedge clk_i) disable iff (rst_i) // R09
            !link[k].ctrl[PIN_ONE_BIT] |=> !pin_analog_o[k*PINS_PER] && !pin_digital_off_o[k*PINS_PER])
            else $error("pin one connected while deselected");

        a_pin_two_off: assert property (@(posedge clk_i) disable iff (rst_i) // R09
            !link[k].ctrl[PIN_TWO_BIT] |=> !pin_analog_o[k*PINS_PER+1] && !pin_digital_off_o[k*PINS_PER+1])
            else $error("pin two connected while deselected");

        a_pin_one_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R11
            pin_analog_o[k*PINS_PER] |-> !pin_read_o[k*PINS_PER])
            else $error("analog pin one read not zero");

        a_digital_pin_read: assert property (@(posedge clk_i) disable iff (rst_i) // R10 R11
            !link[k].ctrl[PIN_ONE_BIT] |=> (pin_read_o[k*PINS_PER] == $past(pin_din_i[k*PINS_PER])))
            else $error("digital pin one read lost");

        a_pos_reserved: assert property (@(posedge clk_i) disable iff (rst_i) // R13
            (link[k].ctrl[POS_SEL_LSB+:SEL_W] == SRC_RESERVED) |=> !source_valid_o[k])
            else $error("reserved positive source not flagged");

        a_neg_reserved: assert property (@(posedge clk_i) disable iff (rst_i) // R14
            (link[k].ctrl[NEG_SEL_LSB+:SEL_W] == SRC_RESERVED) |=> !source_valid_o[k])
            else $error("reserved negative source not flagged");

        a_sources_valid: assert property (@(posedge clk_i) disable iff (rst_i) // R13 R14
            (link[k].ctrl[POS_SEL_LSB+:SEL_W] != SRC_RESERVED)
            && (link[k].ctrl[NEG_SEL_LSB+:SEL_W] == NEG_GROUND) |=> source_valid_o[k])
            else $error("legal sources flagged invalid");

        a_staged_write_held: assert property (@(posedge clk_i) disable iff (rst_i) // R05
            (link[k].wr_high || link[k].wr_low) && !st.load[k] |=> $stable(link[k].active))
            else $error("level write reached active code");

        a_left_high_stage: assert property (@(posedge clk_i) disable iff (rst_i) // R03
            link[k].wr_high && link[k].ctrl[FORMAT_BIT] |=> (link[k].high_rd == $past(link[k].wdata)))
            else $error("left high byte not staged");

        a_right_low_stage: assert property (@(posedge clk_i) disable iff (rst_i) // R04
            link[k].wr_low && !link[k].ctrl[FORMAT_BIT] |=> (link[k].low_rd == $past(link[k].wdata)))
            else $error("right low byte not staged");
    end

    // shared load register view
    always_comb
    begin
        load_rd = ZERO_BYTE;
        for (int k = 0; k < N; k++)
            load_rd[LOAD_BIT[k]] = st.load[k]; // R08
    end

    always_comb
    begin
        next_st = st;
        // ack answers one cycle after the request, then drops
        next_st.ack = req && !st.ack;
        if (req && !st.ack)
        begin
            next_st.rdata = '0;
            if (slot == LOAD_SLOT && word == CTRL_WORD && wb_adr_i[1:0] == 2'h0)
                next_st.rdata[REG_W-1:0] = load_rd; // R08
            else
            begin
                for (int k = 0; k < N; k++)
                    next_st.rdata[REG_W-1:0] = next_st.rdata[REG_W-1:0] | inst_rd[k];
            end
        end
        // strobe is pending for one cycle and clears by itself
        for (int k = 0; k < N; k++)
        begin
            next_st.load[k] = wr_now && (wb_adr_i == LOAD_ADDR) && wb_dat_i[LOAD_BIT[k]]; // R06 R07
            next_st.level[k*CODE_W+:CODE_W] = active_of[k]; // R02 R12
            next_st.enable[k] = ctrl_of[k][ENABLE_BIT]; // R01
            next_st.pos_sel[k*SEL_W+:SEL_W] = ctrl_of[k][POS_SEL_LSB+:SEL_W]; // R13
            next_st.neg_sel[k*SEL_W+:SEL_W] = ctrl_of[k][NEG_SEL_LSB+:SEL_W]; // R14
            next_st.valid[k] = ok_of[k]; // R13 R14
            next_st.pin_analog[k*PINS_PER]   = ctrl_of[k][PIN_ONE_BIT]; // R09 R10
            next_st.pin_analog[k*PINS_PER+1] = ctrl_of[k][PIN_TWO_BIT]; // R09 R10
            next_st.pin_read[k*PINS_PER]     = pin_din_i[k*PINS_PER]
                                            && !ctrl_of[k][PIN_ONE_BIT]; // R11
            next_st.pin_read[k*PINS_PER+1]   = pin_din_i[k*PINS_PER+1]
                                            && !ctrl_of[k][PIN_TWO_BIT]; // R11
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st <= '0; // R15
        else
            st <= next_st;
    end

    assign wb_ack_o          = st.ack;
    assign wb_dat_o          = st.rdata;
    assign pin_read_o        = st.pin_read;
    assign pin_analog_o      = st.pin_analog;
    assign pin_digital_off_o = st.pin_analog; // R10
    assign level_code_o      = st.level;
    assign enable_o          = st.enable;
    assign pos_sel_o         = st.pos_sel;
    assign neg_sel_o         = st.neg_sel;
    assign source_valid_o    = st.valid;

    a_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_ack_o) |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_idle_no_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        !req |=> !wb_ack_o)
        else $error("ack without a bus request");

    a_reset_clears: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        $fell(rst_i) |-> (level_code_o == '0) && (enable_o == '0) && (pin_analog_o == '0))
        else $error("reset did not clear converter outputs");

    a_load_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R08
        (wb_ack_o && !wb_we_i && $past(slot) == LOAD_SLOT && $past(word) == CTRL_WORD)
        |-> (wb_dat_o[REG_W-1:5] == '0) && (wb_dat_o[3:2] == '0))
        else $error("unused load register bits not zero");
endmodule
`default_nettype wire

// *** verilog/dac_ref_pkg.sv ***
`default_nettype none
package dac_ref_pkg;
    // code and register widths
    localparam int CODE_W     = 10;
    localparam int REG_W      = 8;
    localparam int WB_DW      = 32;
    localparam int WB_AW      = 8;
    localparam int SEL_W      = 2;
    localparam int NUM_INST   = 3;
    localparam int PINS_PER   = 2;

    // control register fields
    localparam int ENABLE_BIT    = 7;
    localparam int FORMAT_BIT    = 6;
    localparam int PIN_ONE_BIT   = 5;
    localparam int PIN_TWO_BIT   = 4;
    localparam int POS_SEL_LSB   = 2;
    localparam int NEG_SEL_LSB   = 0;

    // justification layout
    localparam int LEFT_HIGH_LSB  = 2;
    localparam int LEFT_LOW_LSB   = 6;
    localparam int RIGHT_HIGH_LSB = 8;
    localparam int RIGHT_HIGH_W   = 2;
    localparam int RIGHT_LOW_W    = 8;

    // reset values
    localparam logic [REG_W-1:0]  CTRL_RESET  = 8'h00;
    localparam logic [CODE_W-1:0] CODE_RESET  = 10'h000;
    localparam logic [REG_W-1:0]  ZERO_BYTE   = 8'h00;

    // address map: adr[7:4] instance slot, adr[3:2] register word
    localparam int              SLOT_MSB   = 7;
    localparam int              SLOT_LSB   = 4;
    localparam int              WORD_MSB   = 3;
    localparam int              WORD_LSB   = 2;
    localparam logic [1:0]      CTRL_WORD  = 2'h0;
    localparam logic [1:0]      HIGH_WORD  = 2'h1;
    localparam logic [1:0]      LOW_WORD   = 2'h2;
    localparam logic [3:0]      LOAD_SLOT  = 4'h3;
    localparam logic [WB_AW-1:0] LOAD_ADDR = 8'h30;

    // shared load register strobe positions per instance
    localparam int LOAD_BIT [NUM_INST] = '{0, 1, 4};

    // source encodings
    localparam logic [SEL_W-1:0] POS_SUPPLY    = 2'h0;
    localparam logic [SEL_W-1:0] POS_EXT_REF   = 2'h1;
    localparam logic [SEL_W-1:0] POS_FIXED_REF = 2'h2;
    localparam logic [SEL_W-1:0] SRC_RESERVED  = 2'h3;
    localparam logic [SEL_W-1:0] NEG_GROUND    = 2'h0;
    localparam logic [SEL_W-1:0] NEG_REF_ZERO  = 2'h1;
    localparam logic [SEL_W-1:0] NEG_REF_ONE   = 2'h2;
    localparam int               NEG_ONE_INST  = 2;
endpackage
`default_nettype wire

// *** verilog/chan_if.sv ***
`default_nettype none
interface chan_if;
    import dac_ref_pkg::*;
    logic              wr_ctrl;
    logic              wr_high;
    logic              wr_low;
    logic              load;
    logic [REG_W-1:0]  wdata;
    logic [REG_W-1:0]  ctrl;
    logic [REG_W-1:0]  high_rd;
    logic [REG_W-1:0]  low_rd;
    logic [CODE_W-1:0] staged;
    logic [CODE_W-1:0] active;

    modport channel (input wr_ctrl, wr_high, wr_low, load, wdata,
                     output ctrl, high_rd, low_rd, staged, active);
    modport control (output wr_ctrl, wr_high, wr_low, load, wdata,
                     input ctrl, high_rd, low_rd, staged, active);
endinterface
`default_nettype wire

// *** verilog/converter_channel.sv ***
`default_nettype none
module converter_channel
    import dac_ref_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    chan_if.channel   link
);
    typedef struct packed
    {
        logic [REG_W-1:0]  ctrl;
        logic [CODE_W-1:0] staged;
        logic [CODE_W-1:0] active;
    } chan_state_type;

    chan_state_type st;
    chan_state_type next_st;
    logic           left;

    assign left = st.ctrl[FORMAT_BIT];

    always_comb
    begin
        next_st = st;
        // control only changes on a write, not on wake from sleep
        if (link.wr_ctrl)
            next_st.ctrl = link.wdata; // R16
        if (link.wr_high)
        begin
            if (left)
                next_st.staged[CODE_W-1:LEFT_HIGH_LSB] = link.wdata; // R03
            else
                next_st.staged[CODE_W-1:RIGHT_HIGH_LSB] = link.wdata[RIGHT_HIGH_W-1:0]; // R04
        end
        if (link.wr_low)
        begin
            if (left)
                next_st.staged[LEFT_HIGH_LSB-1:0] = link.wdata[REG_W-1:LEFT_LOW_LSB]; // R03
            else
                next_st.staged[RIGHT_LOW_W-1:0] = link.wdata; // R04
        end
        // staged writes never reach active without a load
        if (link.load)
            next_st.active = st.staged; // R05 R06 R07
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st.ctrl   <= CTRL_RESET; // R15
            st.staged <= CODE_RESET; // R15
            st.active <= CODE_RESET; // R15
        end
        else
            st <= next_st;
    end

    assign link.ctrl    = st.ctrl;
    assign link.staged  = st.staged;
    assign link.active  = st.active; // R02
    assign link.high_rd = left ? st.staged[CODE_W-1:LEFT_HIGH_LSB]
                               : {{(REG_W-RIGHT_HIGH_W){1'b0}}, st.staged[CODE_W-1:RIGHT_HIGH_LSB]}; // R03 R04
    assign link.low_rd  = left ? {st.staged[LEFT_HIGH_LSB-1:0], {LEFT_LOW_LSB{1'b0}}}
                               : st.staged[RIGHT_LOW_W-1:0]; // R03 R04

    a_hold_no_load: assert property (@(posedge clk_i) disable iff (rst_i)
        !link.load |=> $stable(st.active)) // R05
        else $error("active code changed without load");
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`default_nettype none
module tb
    import dac_ref_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clk_i;
    logic              rst_i;
    logic              wb_cyc_i;
    logic              wb_stb_i;
    logic              wb_we_i;
    logic [WB_AW-1:0]  wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [WB_DW-1:0]  wb_dat_i;
    logic [WB_DW-1:0]  wb_dat_o;
    logic              wb_ack_o;
    logic [5:0]        pin_din_i;
    logic [5:0]        pin_read_o;
    logic [5:0]        pin_analog_o;
    logic [5:0]        pin_digital_off_o;
    logic [29:0]       level_code_o;
    logic [2:0]        enable_o;
    logic [5:0]        pos_sel_o;
    logic [5:0]        neg_sel_o;
    logic [2:0]        source_valid_o;
    logic [7:0]        ctrl_m [3];
    logic [9:0]        stage_m [3];
    logic [9:0]        act_m [3];
    logic [31:0]       rd;
    int                failures;
    int                compares;
    int                cycles;
    integer            seed;
    int                load_q [$];

    dac_ref_ctrl #(.N(3)) dac_ref_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_din_i(pin_din_i),
        .pin_read_o(pin_read_o), .pin_analog_o(pin_analog_o), .pin_digital_off_o(pin_digital_off_o),
        .level_code_o(level_code_o), .enable_o(enable_o), .pos_sel_o(pos_sel_o),
        .neg_sel_o(neg_sel_o), .source_valid_o(source_valid_o));

    always #50 clk_i = ~clk_i;

    task automatic end_of_test();
        if (failures == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // expected register image
    function automatic logic [31:0] model_read(input logic [7:0] adr);
        int k;
        logic fm;
        k = adr[7:4];
        if (adr[1:0] != 2'h0 || k > 2)
            return 32'h0;
        fm = ctrl_m[k][FORMAT_BIT];
        case (adr[3:2])
            CTRL_WORD: return {24'h0, ctrl_m[k]};
            HIGH_WORD: return fm ? {24'h0, stage_m[k][9:2]} : {30'h0, stage_m[k][9:8]};
            LOW_WORD:  return fm ? {24'h0, stage_m[k][1:0], 6'h0} : {24'h0, stage_m[k][7:0]};
            default:   return 32'h0;
        endcase
    endfunction

    task automatic model_write(input logic [7:0] adr, input logic [7:0] d, input logic [3:0] sel);
        int k;
        logic fm;
        k = adr[7:4];
        if (!sel[0] || adr[1:0] != 2'h0)
            return;
        if (adr == LOAD_ADDR)
        begin
            for (int i = 0; i < 3; i++)
                if (d[LOAD_BIT[i]])
                    load_q.push_back(i);
            while (load_q.size() > 0)
            begin
                act_m[load_q[0]] = stage_m[load_q[0]];
                void'(load_q.pop_front());
            end
            return;
        end
        if (k > 2)
            return;
        fm = ctrl_m[k][FORMAT_BIT];
        case (adr[3:2])
            CTRL_WORD: ctrl_m[k] = d;
            HIGH_WORD: if (fm) stage_m[k][9:2] = d; else stage_m[k][9:8] = d[1:0];
            LOW_WORD:  if (fm) stage_m[k][1:0] = d[7:6]; else stage_m[k][7:0] = d;
            default:   ;
        endcase
    endtask

    // one classic single cycle, released after the ack edge
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {$random(seed)} & 32'hFFFFFF00 | {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        check({31'h0, wb_ack_o}, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (we)
            model_write(adr, d, sel);
        else
            check(rd, model_read(adr));
    endtask

    task automatic settle();
        logic [5:0] an;
        pin_din_i <= $random(seed);
        repeat (3) @(posedge clk_i);
        for (int k = 0; k < 3; k++)
        begin
            an[2*k]   = ctrl_m[k][PIN_ONE_BIT];
            an[2*k+1] = ctrl_m[k][PIN_TWO_BIT];
            check(level_code_o[k*CODE_W +: CODE_W], act_m[k]);
            check(enable_o[k], ctrl_m[k][ENABLE_BIT]);
            check(pos_sel_o[k*SEL_W +: SEL_W], ctrl_m[k][3:2]);
            check(neg_sel_o[k*SEL_W +: SEL_W], ctrl_m[k][1:0]);
            check(source_valid_o[k], ctrl_m[k][3:2] != 2'h3 && ctrl_m[k][1:0] != 2'h3
                  && !(ctrl_m[k][1:0] == 2'h2 && k != NEG_ONE_INST));
        end
        check(pin_analog_o, an);
        check(pin_digital_off_o, an);
        check(pin_read_o, pin_din_i & ~an);
    endtask

    task automatic read_all();
        for (int k = 0; k < 3; k++)
            for (int w = 0; w < 4; w++)
                bus(1'b0, 8'(k * 16 + w * 4), 8'h00, 4'hF);
        bus(1'b0, LOAD_ADDR, 8'h00, 4'hF);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            ctrl_m[k]  = 8'h00;
            stage_m[k] = 10'h000;
            act_m[k]   = 10'h000;
        end
    endtask

    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        pin_din_i = 6'h00;
        {failures, compares, cycles} = 0;
        seed = 32'h8b59;
        do_reset();
        settle();
        read_all();
        // staged writes in both formats, then per instance load
        for (int k = 0; k < 3; k++)
            for (int fm = 0; fm < 2; fm++)
            begin
                bus(1'b1, 8'(k * 16), 8'($random(seed)) & 8'hBF | 8'(fm << FORMAT_BIT), 4'h1);
                bus(1'b1, 8'(k * 16 + 4), 8'($random(seed)), 4'h1);
                bus(1'b1, 8'(k * 16 + 8), 8'($random(seed)), 4'h1);
                settle();
                read_all();
                bus(1'b1, LOAD_ADDR, 8'(1 << LOAD_BIT[k]) | 8'($random(seed)) & 8'hEC, 4'h1);
                settle();
                bus(1'b1, LOAD_ADDR, 8'hEC, 4'h1);
                settle();
            end
        // every source code on every instance
        for (int v = 0; v < 16; v++)
            for (int k = 0; k < 3; k++)
            begin
                bus(1'b1, 8'(k * 16), {4'($random(seed)), 4'(v)}, 4'hF);
                bus(1'b1, 8'(k * 16 + 4), 8'($random(seed)), 4'h1);
            end
        settle();
        read_all();
        // all three loaded together, unmapped and byte-lane refused writes
        bus(1'b1, LOAD_ADDR, 8'h13, 4'h1);
        bus(1'b1, 8'h00, 8'hFF, 4'h2);
        bus(1'b1, 8'h0C, 8'hFF, 4'h1);
        bus(1'b1, 8'h41, 8'hFF, 4'h1);
        bus(1'b0, 8'h31, 8'h00, 4'hF);
        bus(1'b0, 8'hF0, 8'h00, 4'hF);
        settle();
        read_all();
        // converters switched off before a quiet stretch, control kept
        for (int k = 0; k < 3; k++)
            bus(1'b1, 8'(k * 16), 8'($random(seed)) & 8'h7F, 4'h1);
        repeat (20) @(posedge clk_i);
        settle();
        read_all();
        // reset in mid-run
        do_reset();
        settle();
        read_all();
        end_of_test();
    end
endmodule
`default_nettype wire
